// ==== logic/wasc_pkg.sv ====
`default_nettype none
package wasc_pkg;
    // register bus geometry
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [1:0] OFS_CTRL   = 2'h0;
    localparam logic [1:0] OFS_SDSTAT = 2'h1;
    localparam logic [1:0] OFS_IRQST  = 2'h2;
    localparam logic [1:0] OFS_IRQMSK = 2'h3;

    // shutdown control field positions
    localparam int unsigned BIT_EVENT   = 7;
    localparam int unsigned BIT_ARSEN   = 6;
    localparam int unsigned BIT_FLTEN   = 1;
    localparam int unsigned BIT_LCEN    = 0;
    // output setting register field positions
    localparam int unsigned BIT_POL     = 2;
    localparam int unsigned BIT_STATE_H = 1;
    localparam int unsigned BIT_STATE_L = 0;
    // interrupt status / mask positions
    localparam int unsigned IRQ_ENTER   = 0;
    localparam int unsigned IRQ_RESTART = 1;
    localparam int unsigned IRQ_N       = 2;

    // reset values
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [2:0] RST_SDSET  = 3'h0;
    localparam logic [1:0] RST_IRQ    = 2'h0;

    // shutdown output state codes
    typedef enum logic [1:0] {
        WASC_SD_INACTIVE = 2'b00,
        WASC_SD_TRISTATE = 2'b01,
        WASC_SD_LOW      = 2'b10,
        WASC_SD_HIGH     = 2'b11
    } wasc_sdstate_e;
endpackage
`default_nettype wire

// ==== logic/wasc_out_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface wasc_out_if;
    logic       eventFlag;
    logic [1:0] sdState;
    logic       polarity;
    logic       waveIn;
    logic       pinOut;
    logic       pinOe;

    modport ctl (output eventFlag, output sdState, output polarity,
                 output waveIn, input pinOut, input pinOe);
    modport drv (input eventFlag, input sdState, input polarity,
                 input waveIn, output pinOut, output pinOe);
endinterface
`default_nettype wire

// ==== logic/wasc_out_stage.sv ====
`timescale 1ns/1ns
`default_nettype none
module wasc_out_stage
    import wasc_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // controls and pin drive
    wasc_out_if.drv   io
);
    // ------------------------------------------------------------
    // pin drive selection
    // ------------------------------------------------------------
    wire logic normLevel = io.waveIn ^ io.polarity;
    wire logic idleLevel = io.polarity;
    wire logic sdLevel;
    wire logic sdOe;
    wire logic outNext;
    wire logic oeNext;
    logic      out_reg;
    logic      oe_reg;

    assign sdLevel = (io.sdState == WASC_SD_HIGH)     ? 1'b1 :
                     (io.sdState == WASC_SD_LOW)      ? 1'b0 :
                     (io.sdState == WASC_SD_INACTIVE) ? idleLevel :
                     1'b0;
    assign sdOe    = (io.sdState != WASC_SD_TRISTATE);
    assign outNext = io.eventFlag ? sdLevel : normLevel;
    assign oeNext  = io.eventFlag ? sdOe : 1'b1;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            out_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end
        else
        begin
            out_reg <= outNext;
            oe_reg  <= oeNext;
        end
    end

    assign io.pinOut = out_reg;
    assign io.pinOe  = oe_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_TRISTATE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        io.eventFlag && io.sdState == WASC_SD_TRISTATE |=> !io.pinOe)
        else $error("pin driven in tri-state shutdown code");
    AST_FORCE_HIGH: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        io.eventFlag && io.sdState == WASC_SD_HIGH
        |=> io.pinOe && io.pinOut)
        else $error("pin not forced high in shutdown");
    AST_FORCE_LOW: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        io.eventFlag && io.sdState == WASC_SD_LOW
        |=> io.pinOe && !io.pinOut)
        else $error("pin not forced low in shutdown");
    AST_IDLE_LEVEL: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        io.eventFlag && io.sdState == WASC_SD_INACTIVE
        |=> io.pinOe && io.pinOut == $past(io.polarity))
        else $error("pin not at idle level in shutdown");
    COV_TRISTATE: cover property (@(posedge sys_clk) disable iff (!nrst)
        io.eventFlag && !io.pinOe);
endmodule
`default_nettype wire

// ==== logic/wasc_shutdown_ctrl.sv ====
// Summary of operation
// - bit 7 reads one after a shutdown event, zero otherwise.
// - bit 6 enables automatic restart when written one, disables at zero.
// - bits 5 to 2 of shutdown control always read zero.
// - with bit 1 set, low fault input shuts down; otherwise ignored.
// - with bit 0 set, high logic cell two output shuts down.
// - during shutdown output follows state field; code 01 tri-states.
// - state code 11 forces high, 10 forces low, ignoring polarity.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module wasc_shutdown_ctrl
(
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          nrst,
    // register port
    input  wire logic [wasc_pkg::ADDR_W-1:0]   regAddr,
    input  wire logic [wasc_pkg::DATA_W-1:0]   regWdata,
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    output var  logic [wasc_pkg::DATA_W-1:0]   regRdata,
    // shutdown sources
    input  wire logic                          external_fault_input_n,
    input  wire logic                          logic_cell2_output,
    // waveform in and primary pin
    input  wire logic                          waveIn,
    output var  logic                          primaryOut,
    output var  logic                          primaryOe,
    // status
    output var  logic                          shutdownActive,
    output var  logic                          irq
);
    import wasc_pkg::*;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire logic wrCtrl  = regWr && (regAddr == OFS_CTRL);
    wire logic wrSdset = regWr && (regAddr == OFS_SDSTAT);
    wire logic wrIrqSt = regWr && (regAddr == OFS_IRQST);
    wire logic wrIrqMk = regWr && (regAddr == OFS_IRQMSK);

    logic                 eventFlag_reg;
    logic                 arsen_reg;
    logic                 fltEn_reg;
    logic                 lcEn_reg;
    logic [2:0]           sdset_reg;
    logic [IRQ_N-1:0]     irqSt_reg;
    logic [IRQ_N-1:0]     irqMk_reg;
    logic [DATA_W-1:0]    rdata_reg;
    logic                 irq_reg;

    // ------------------------------------------------------------
    // shutdown sources and event flag
    // ------------------------------------------------------------
    wire logic fltTrig = fltEn_reg && !external_fault_input_n;
    wire logic lcTrig  = lcEn_reg && logic_cell2_output;
    wire logic srcActive = fltTrig || lcTrig;
    wire logic autoClr = eventFlag_reg && arsen_reg && !srcActive;
    wire logic eventNext;

    // source set wins; software write next; auto clear last
    assign eventNext = srcActive ? 1'b1 :
                       wrCtrl    ? regWdata[BIT_EVENT] :
                       autoClr   ? 1'b0 :
                       eventFlag_reg;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            eventFlag_reg <= RST_CTRL[BIT_EVENT];
            arsen_reg     <= RST_CTRL[BIT_ARSEN];
            fltEn_reg     <= RST_CTRL[BIT_FLTEN];
            lcEn_reg      <= RST_CTRL[BIT_LCEN];
        end
        else
        begin
            eventFlag_reg <= eventNext;
            if (wrCtrl)
            begin
                arsen_reg <= regWdata[BIT_ARSEN];
                fltEn_reg <= regWdata[BIT_FLTEN];
                lcEn_reg  <= regWdata[BIT_LCEN];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            sdset_reg <= RST_SDSET;
        else if (wrSdset)
            sdset_reg <= regWdata[2:0];
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire logic enterEv   = eventNext && !eventFlag_reg;
    wire logic restartEv = autoClr && !srcActive && !wrCtrl;
    wire logic [IRQ_N-1:0] irqSet = {restartEv, enterEv};
    wire logic [IRQ_N-1:0] irqClr = wrIrqSt ? regWdata[IRQ_N-1:0]
                                            : {IRQ_N{1'b0}};
    wire logic [IRQ_N-1:0] irqStNext = irqSet | (irqSt_reg & ~irqClr);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irqSt_reg <= RST_IRQ;
            irqMk_reg <= RST_IRQ;
            irq_reg   <= 1'b0;
        end
        else
        begin
            irqSt_reg <= irqStNext;
            if (wrIrqMk)
                irqMk_reg <= regWdata[IRQ_N-1:0];
            irq_reg <= |(irqStNext & irqMk_reg);
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire logic [DATA_W-1:0] ctrlView = {eventFlag_reg, arsen_reg,
                                        4'h0, fltEn_reg, lcEn_reg};
    wire logic [DATA_W-1:0] rdMux =
        (regAddr == OFS_CTRL)   ? ctrlView :
        (regAddr == OFS_SDSTAT) ? {5'h00, sdset_reg} :
        (regAddr == OFS_IRQST)  ? {6'h00, irqSt_reg} :
                                  {6'h00, irqMk_reg};

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            rdata_reg <= 8'h00;
        else if (regRd)
            rdata_reg <= rdMux;
        else
            rdata_reg <= 8'h00;
    end

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    wasc_out_if outIf ();
    assign outIf.eventFlag = eventFlag_reg;
    assign outIf.sdState   = sdset_reg[BIT_STATE_H:BIT_STATE_L];
    assign outIf.polarity  = sdset_reg[BIT_POL];
    assign outIf.waveIn    = waveIn;

    wasc_out_stage u_out (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .io      (outIf.drv)
    );

    assign regRdata       = rdata_reg;
    assign primaryOut     = outIf.pinOut;
    assign primaryOe      = outIf.pinOe;
    assign shutdownActive = eventFlag_reg;
    assign irq            = irq_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_FLAG_READ: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        regRd && regAddr == OFS_CTRL
        |=> regRdata[BIT_EVENT] == $past(eventFlag_reg))
        else $error("event flag read back wrong");
    AST_ARSEN_WR: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wrCtrl |=> arsen_reg == $past(regWdata[BIT_ARSEN]))
        else $error("auto-restart enable not stored");
    AST_CFG_HOLD: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !wrCtrl |=> $stable(arsen_reg))
        else $error("auto-restart enable changed without a write");
    AST_RSV_ZERO: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        regRd && regAddr == OFS_CTRL |=> regRdata[5:2] == 4'h0)
        else $error("unimplemented bits read nonzero");
    AST_RD_IDLE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !regRd |=> regRdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_FAULT_TRIG: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        fltTrig |=> eventFlag_reg
            ##1 primaryOe == (sdset_reg[1:0] != 2'b01))
        else $error("fault input did not shut down");
    AST_FAULT_IGNORED: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !fltEn_reg && !lcTrig && !eventFlag_reg && !wrCtrl
        |=> !eventFlag_reg)
        else $error("disabled source caused shutdown");
    AST_LC_TRIG: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        lcEn_reg && logic_cell2_output |=> eventFlag_reg)
        else $error("logic cell output did not shut down");
    AST_AUTO_CLR: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        eventFlag_reg && arsen_reg && !srcActive && !wrCtrl
        |=> !eventFlag_reg)
        else $error("auto-restart did not clear event");
    AST_HOLD: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        eventFlag_reg && !arsen_reg && !wrCtrl |=> eventFlag_reg)
        else $error("event cleared without software");
    AST_SW_CLEAR: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wrCtrl && !regWdata[BIT_EVENT] && !srcActive
        |=> !eventFlag_reg)
        else $error("software clear of event ignored");
    AST_SW_FORCE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wrCtrl && regWdata[BIT_EVENT] |=> eventFlag_reg)
        else $error("software forced shutdown ignored");
    AST_IRQ_SET: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        enterEv |=> irqSt_reg[IRQ_ENTER])
        else $error("shutdown entry not latched in status");
    AST_IRQ_W1C: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wrIrqSt && regWdata[IRQ_ENTER] && !enterEv
        |=> !irqSt_reg[IRQ_ENTER])
        else $error("entry status not cleared by write one");
    AST_IRQ_LEVEL: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !wrIrqMk |=> irq == |(irqSt_reg & irqMk_reg))
        else $error("interrupt level disagrees with status and mask");

    COV_FAULT: cover property (@(posedge sys_clk) disable iff (!nrst)
        fltTrig ##1 eventFlag_reg);
    COV_RESTART: cover property (@(posedge sys_clk) disable iff (!nrst)
        eventFlag_reg && arsen_reg ##1 !eventFlag_reg);
    COV_IRQ: cover property (@(posedge sys_clk) disable iff (!nrst)
        $rose(irq_reg));
endmodule
`default_nettype wire

// ==== logic/wasc_dummy_unused.sv ====
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== tb/wasc_src_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module wasc_src_model
(
    // clock
    input  wire logic sys_clk,
    // commands from the bench
    input  wire logic faultReq,
    input  wire logic cellReq,
    // source levels
    output var  logic external_fault_input_n = 1'b1,
    output var  logic logic_cell2_output = 1'b0
);
    // levels move on the clock only, as synchronised sources do
    always @(posedge sys_clk)
    begin
        external_fault_input_n <= !faultReq;
        logic_cell2_output     <= cellReq;
    end
endmodule
`default_nettype wire

// ==== tb/waveform_auto_shutdown_control_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module waveform_auto_shutdown_control_test;
    import wasc_pkg::*;
    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWdata = 8'h00;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic [7:0] regRdata;
    logic       faultReq = 1'b0;
    logic       cellReq = 1'b0;
    logic       faultN;
    logic       cellOut;
    logic       waveIn = 1'b0;
    logic       primaryOut;
    logic       primaryOe;
    logic       shutdownActive;
    logic       irq;
    logic [7:0] rdv;
    int         error_cnt = 0;
    int         comparisons = 0;
    wasc_src_model u_wasc_src_model (.sys_clk(sys_clk), .faultReq(faultReq),
        .cellReq(cellReq), .external_fault_input_n(faultN),
        .logic_cell2_output(cellOut));
    wasc_shutdown_ctrl u_wasc_shutdown_ctrl (.sys_clk(sys_clk), .nrst(nrst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata),
        .external_fault_input_n(faultN), .logic_cell2_output(cellOut),
        .waveIn(waveIn), .primaryOut(primaryOut), .primaryOe(primaryOe),
        .shutdownActive(shutdownActive), .irq(irq));
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr    <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_flag(input logic exp);
        int n = 0;
        while (shutdownActive !== exp && n < 20)
        begin
            idle(1);
            n++;
        end
        if (shutdownActive !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t flag wait timed out", $time);
            stop_test();
        end
    endtask
    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic test_reset();
        rd(OFS_CTRL, rdv);
        chk(rdv, 8'h00, "ctrl reset");
        rd(OFS_IRQST, rdv);
        chk(rdv, 8'h00, "irq status reset");
        chk({6'h0, primaryOe, primaryOut}, 8'h02, "normal pin");
        waveIn <= 1'b1;
        idle(2);
        chk({6'h0, primaryOe, primaryOut}, 8'h03, "wave follows");
        waveIn <= 1'b0;
        $display("test reset done");
    endtask
    task automatic test_fields();
        wr(OFS_CTRL, 8'h7F);
        rd(OFS_CTRL, rdv);
        chk(rdv, 8'h43, "ctrl fields");
        wr(OFS_CTRL, 8'h00);
        rd(OFS_CTRL, rdv);
        chk(rdv, 8'h00, "ctrl cleared");
        $display("test fields done");
    endtask
    task automatic test_fault_latch();
        wr(OFS_IRQST, 8'h03);
        wr(OFS_IRQMSK, 8'h01);
        wr(OFS_SDSTAT, 8'h03);
        wr(OFS_CTRL, 8'h02);
        faultReq <= 1'b1;
        wait_flag(1'b1);
        rd(OFS_CTRL, rdv);
        chk(rdv, 8'h82, "fault latched");
        chk({6'h0, primaryOe, primaryOut}, 8'h03, "forced high");
        chk({7'h0, irq}, 8'h01, "irq raised");
        faultReq <= 1'b0;
        idle(4);
        chk({7'h0, shutdownActive}, 8'h01, "flag sticky");
        wr(OFS_CTRL, 8'h02);
        idle(2);
        chk({7'h0, shutdownActive}, 8'h00, "sw clear");
        wr(OFS_IRQST, 8'h01);
        idle(2);
        chk({7'h0, irq}, 8'h00, "irq cleared");
        $display("test fault latch done");
    endtask
    task automatic test_fault_off();
        wr(OFS_CTRL, 8'h00);
        faultReq <= 1'b1;
        idle(5);
        chk({7'h0, shutdownActive}, 8'h00, "fault ignored");
        faultReq <= 1'b0;
        $display("test fault off done");
    endtask
    task automatic test_cell_restart();
        wr(OFS_IRQST, 8'h03);
        wr(OFS_IRQMSK, 8'h00);
        wr(OFS_SDSTAT, 8'h06);
        wr(OFS_CTRL, 8'h41);
        idle(2);
        chk({6'h0, primaryOe, primaryOut}, 8'h03, "inverted normal");
        cellReq <= 1'b1;
        wait_flag(1'b1);
        idle(1);
        chk({6'h0, primaryOe, primaryOut}, 8'h02, "forced low");
        chk({7'h0, irq}, 8'h00, "irq masked");
        cellReq <= 1'b0;
        wait_flag(1'b0);
        rd(OFS_IRQST, rdv);
        chk(rdv, 8'h03, "enter and restart status");
        $display("test cell restart done");
    endtask
    task automatic test_states();
        logic [1:0] code;
        logic [7:0] pinv;
        wr(OFS_CTRL, 8'h00);
        waveIn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            code = 2'(i);
            wr(OFS_SDSTAT, {6'h01, code});
            wr(OFS_CTRL, 8'h80);
            idle(2);
            pinv = {6'h0, primaryOe, primaryOut};
            if (code == 2'b01)
                chk({7'h0, primaryOe}, 8'h00, "tristate");
            else if (code == 2'b00)
                chk(pinv, 8'h03, "idle level");
            else
                chk(pinv, {7'h01, code[0]}, "forced level");
            wr(OFS_CTRL, 8'h00);
            idle(2);
            pinv = {6'h0, primaryOe, primaryOut};
            chk(pinv, 8'h02, "normal again");
        end
        waveIn <= 1'b0;
        $display("test states done");
    endtask
    task automatic test_midreset();
        wr(OFS_CTRL, 8'hC0);
        idle(1);
        nrst <= 1'b0;
        idle(2);
        chk({5'h0, shutdownActive, primaryOe, primaryOut}, 8'h00, "in reset");
        nrst <= 1'b1;
        rd(OFS_CTRL, rdv);
        chk(rdv, 8'h00, "ctrl after reset");
        $display("test midreset done");
    endtask
    initial
    begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        test_reset();
        test_fields();
        test_fault_latch();
        test_fault_off();
        test_cell_restart();
        test_states();
        test_midreset();
        stop_test();
    end
endmodule
`default_nettype wire
